// ### hw/csb_bit_select.v
`timescale 1ns/1ps
`include "csb_defines.vh"
// picks one bit of an 8-bit operand
module csb_bit_select (
  // operand
  input wire [7:0] data_in,
  input wire [2:0] index_in,
  // selected bit
  output wire bit_out
);
  wire [7:0] hit;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      assign hit[i] = data_in[i] & ({29'h0, index_in} == i);
    end
  endgenerate
  assign bit_out = |hit;
endmodule

// ### hw/csb_cond_skip_branch.v
`timescale 1ns/1ps
`include "csb_defines.vh"
module csb_cond_skip_branch (
  // clock and reset
  input wire clock_in,
  input wire sys_rst_in,
  // instruction request
  input wire start_in,
  input wire [2:0] op_in,
  input wire [2:0] bit_index_in,
  input wire [`CSB_OFS_W-1:0] offset_in,
  input wire next_two_word_in,
  input wire [`CSB_PC_W-1:0] pc_in,
  // operands
  input wire [7:0] work_reg_in,
  input wire [7:0] io_reg_in,
  input wire [7:0] core_flag_register_in,
  // results
  output wire [`CSB_PC_W-1:0] pc_out,
  output wire pc_load_out,
  output wire taken_out,
  output wire busy_out,
  output wire done_out,
  output wire [7:0] core_flag_register_out
);
  // sequencer states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT1 = 2'h1;
  localparam [1:0] ST_WAIT2 = 2'h2;

  // sequencer and output registers
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`CSB_PC_W-1:0] pc_reg;
  reg [`CSB_PC_W-1:0] pc_next;
  reg pc_load_reg;
  reg pc_load_next;
  reg taken_reg;
  reg taken_next;
  reg busy_reg;
  reg busy_next;
  reg done_reg;
  reg done_next;
  reg [7:0] flag_copy_reg;
  reg [7:0] flag_copy_next;

  // decode
  reg [7:0] operand;
  wire sel_bit;
  reg cond;
  reg is_branch;
  reg [`CSB_PC_W-1:0] target;
  reg [1:0] wait_cnt;
  wire [`CSB_PC_W-1:0] ofs_ext;
  wire accept;

  // operand that holds the tested bit
  always @* begin
    case (op_in)
      `CSB_OP_SKIP_REG_SET: operand = work_reg_in;
      `CSB_OP_SKIP_IO_CLEAR: operand = io_reg_in;
      `CSB_OP_SKIP_IO_SET: operand = io_reg_in;
      default: operand = core_flag_register_in;
    endcase
  end

  csb_bit_select u_sel (
    .data_in(operand),
    .index_in(bit_index_in),
    .bit_out(sel_bit)
  );

  // sign-extended offset; a request is taken only while idle
  assign ofs_ext = {{(`CSB_PC_W-`CSB_OFS_W){offset_in[`CSB_OFS_W-1]}}, offset_in};
  assign accept = start_in & (state_reg == ST_IDLE);

  // condition per instruction
  always @* begin
    cond = 1'h0;
    is_branch = 1'h0;
    case (op_in)
      `CSB_OP_SKIP_REG_SET: cond = sel_bit;
      `CSB_OP_SKIP_IO_CLEAR: cond = ~sel_bit;
      `CSB_OP_SKIP_IO_SET: cond = sel_bit;
      `CSB_OP_BRANCH_FLAG_SET: begin
        cond = sel_bit;
        is_branch = 1'h1;
      end
      `CSB_OP_BRANCH_FLAG_CLEAR: begin
        cond = ~sel_bit;
        is_branch = 1'h1;
      end
      default: cond = 1'h0;
    endcase
  end

  // new pc and extra busy cycles
  always @* begin
    wait_cnt = 2'h0;
    if (!cond) begin
      target = pc_in + 16'h0001;
    end else if (is_branch) begin
      target = pc_in + ofs_ext + 16'h0001;
      wait_cnt = `CSB_WAIT_BRANCH;
    end else if (next_two_word_in) begin
      target = pc_in + 16'h0003;
      wait_cnt = `CSB_WAIT_SKIP2;
    end else begin
      target = pc_in + 16'h0002;
      wait_cnt = `CSB_WAIT_SKIP1;
    end
  end

  // sequencer: extra cycles before done
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept && wait_cnt == `CSB_WAIT_SKIP2) begin
          state_next = ST_WAIT2;
        end else if (accept && wait_cnt != 2'h0) begin
          state_next = ST_WAIT1;
        end
      end
      ST_WAIT2: begin
        state_next = ST_WAIT1;
      end
      ST_WAIT1: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // next values of the outputs
  always @* begin
    pc_next = pc_reg;
    pc_load_next = 1'h0;
    taken_next = taken_reg;
    busy_next = busy_reg;
    done_next = 1'h0;
    // flags pass through unchanged for every instruction here
    flag_copy_next = core_flag_register_in;
    if (accept) begin
      pc_next = target;
      pc_load_next = 1'h1;
      taken_next = cond;
      busy_next = (wait_cnt != 2'h0);
      done_next = (wait_cnt == 2'h0);
    end else if (state_reg == ST_WAIT1) begin
      busy_next = 1'h0;
      done_next = 1'h1;
    end
  end

  // sequencer and output registers
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_reg <= `CSB_PC_RST;
    end else begin
      pc_reg <= pc_next;
    end
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_load_reg <= 1'h0;
    end else begin
      pc_load_reg <= pc_load_next;
    end
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      taken_reg <= 1'h0;
    end else begin
      taken_reg <= taken_next;
    end
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_reg <= 1'h0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      done_reg <= 1'h0;
    end else begin
      done_reg <= done_next;
    end
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flag_copy_reg <= 8'h00;
    end else begin
      flag_copy_reg <= flag_copy_next;
    end
  end

  // outputs straight from the registers
  assign pc_out = pc_reg;
  assign pc_load_out = pc_load_reg;
  assign taken_out = taken_reg;
  assign busy_out = busy_reg;
  assign done_out = done_reg;
  assign core_flag_register_out = flag_copy_reg;
endmodule

// ### hw/csb_defines.vh
`ifndef CSB_DEFINES_VH
`define CSB_DEFINES_VH
// operation codes presented with a start strobe
`define CSB_OP_SKIP_REG_SET 3'h0
`define CSB_OP_SKIP_IO_CLEAR 3'h1
`define CSB_OP_SKIP_IO_SET 3'h2
`define CSB_OP_BRANCH_FLAG_SET 3'h3
`define CSB_OP_BRANCH_FLAG_CLEAR 3'h4
// widths and reset values
`define CSB_PC_W 16
`define CSB_OFS_W 7
`define CSB_PC_RST 16'h0000
// extra busy cycles: taken branch 1, one-word skip 1, two-word skip 2
`define CSB_WAIT_BRANCH 2'h1
`define CSB_WAIT_SKIP1 2'h1
`define CSB_WAIT_SKIP2 2'h2
`endif

// ### verification/conditional_skip_branch_test.sv
`timescale 1ns/1ps
`define CK(n,e,g) begin num_checks++; if((g)!==(e)) begin err_total++; $display("MISMATCH %s %0h %0h",n,e,g); end end
module conditional_skip_branch_test;
  reg clock_in=0, sys_rst_in=1, start_in=0, next_two_word_in=0;
  reg [2:0] op_in=0, bit_index_in=0;
  reg [6:0] offset_in=0;
  reg [15:0] pc_in=0;
  reg [7:0] work_reg_in=0, io_reg_in=0, core_flag_register_in=0;
  wire [15:0] pc_out;
  wire pc_load_out, taken_out, busy_out, done_out;
  wire [7:0] core_flag_register_out;
  int err_total=0, num_checks=0;
  always #4 clock_in=~clock_in;
  csb_cond_skip_branch dut(
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .start_in(start_in),
    .op_in(op_in),
    .bit_index_in(bit_index_in),
    .offset_in(offset_in),
    .next_two_word_in(next_two_word_in),
    .pc_in(pc_in),
    .work_reg_in(work_reg_in),
    .io_reg_in(io_reg_in),
    .core_flag_register_in(core_flag_register_in),
    .pc_out(pc_out),
    .pc_load_out(pc_load_out),
    .taken_out(taken_out),
    .busy_out(busy_out),
    .done_out(done_out),
    .core_flag_register_out(core_flag_register_out)
  );
  task conclude;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total==0 && num_checks>0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task issue(input [2:0] o, b, input [6:0] k, input t, input [7:0] v, input [15:0] p, ep, input et, input int n);
    int c;
    @(negedge clock_in);
    {op_in, bit_index_in, offset_in, next_two_word_in, pc_in, start_in} = {o, b, k, t, p, 1'b1};
    {work_reg_in, io_reg_in, core_flag_register_in} = {v, v, v};
    @(negedge clock_in);
    start_in=0;
    `CK("pc", ep, pc_out)
    `CK("taken", et, taken_out)
    `CK("flags", v, core_flag_register_out)
    `CK("load", 1'h1, pc_load_out)
    `CK("busy", n>1, busy_out)
    c=1;
    while (!done_out && c<5) begin
      @(negedge clock_in);
      c++;
      `CK("load off", 1'h0, pc_load_out)
    end
    `CK("cycles", n, c)
    `CK("busy end", 1'h0, busy_out)
    if (c==5) conclude;
  endtask
  task skip_reg;
    issue(0, 3, 0, 0, 8'h08, 16'h0010, 16'h0012, 1, 2);
    issue(0, 7, 0, 1, 8'h80, 16'hfffe, 16'h0001, 1, 3);
    issue(0, 3, 0, 1, 8'hf7, 16'h0010, 16'h0011, 0, 1);
  endtask
  task skip_io;
    issue(1, 0, 0, 1, 8'hfe, 16'h0020, 16'h0023, 1, 3);
    issue(1, 0, 0, 0, 8'h01, 16'h0020, 16'h0021, 0, 1);
    issue(2, 5, 0, 0, 8'h20, 16'h0030, 16'h0032, 1, 2);
    issue(2, 5, 0, 1, 8'hdf, 16'h0030, 16'h0031, 0, 1);
    issue(2, 5, 0, 1, 8'h20, 16'h0030, 16'h0033, 1, 3);
  endtask
  task branch_set;
    issue(3, 2, 7'h7f, 0, 8'h04, 16'h0100, 16'h0100, 1, 2);
    issue(3, 2, 7'h3f, 0, 8'h04, 16'h0100, 16'h0140, 1, 2);
    issue(3, 2, 7'h3f, 1, 8'hfb, 16'h0100, 16'h0101, 0, 1);
  endtask
  task branch_clr;
    issue(4, 6, 7'h40, 0, 8'hbf, 16'h0100, 16'h00c1, 1, 2);
    issue(4, 6, 7'h40, 1, 8'h40, 16'h0100, 16'h0101, 0, 1);
    issue(5, 0, 0, 1, 8'hff, 16'h0200, 16'h0201, 0, 1);
  endtask
  initial begin
    repeat (20) @(negedge clock_in);
    sys_rst_in=0;
    skip_reg;
    skip_io;
    branch_set;
    branch_clr;
    conclude;
  end
endmodule

// ### verification/csb_cond_skip_branch_props.sv
`timescale 1ns/1ps
module csb_props(input logic clock_in, sys_rst_in, start_in, next_two_word_in, pc_load_out, taken_out, busy_out,
  input logic done_out, input logic [2:0] op_in, bit_index_in, input logic [6:0] offset_in,
  input logic [15:0] pc_in, pc_out, input logic [7:0] work_reg_in, io_reg_in, core_flag_register_in,
  input logic [7:0] core_flag_register_out);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire go = start_in & !busy_out & !done_out;
  a_skip_reg_pc: assert property (go && op_in==0 && work_reg_in[bit_index_in] |=>
    taken_out && pc_out==16'($past(pc_in)+($past(next_two_word_in)?3:2))) else $error("skip reg pc wrong");
  a_io_clear_skip: assert property (go && op_in==1 && !io_reg_in[bit_index_in] |=> taken_out) else $error("io clr");
  a_io_set_skip: assert property (go && op_in==2 && io_reg_in[bit_index_in] |=> taken_out) else $error("io set");
  a_branch_set_pc: assert property (go && op_in==3 && core_flag_register_in[bit_index_in] |=>
    pc_out==16'($past(pc_in)+$past({{9{offset_in[6]}},offset_in})+1) ##1 done_out) else $error("branch set");
  a_branch_clear_go: assert property (go && op_in==4 && !core_flag_register_in[bit_index_in] |=>
    taken_out ##1 done_out) else $error("branch clr");
  a_not_taken: assert property (go ##1 !taken_out |-> pc_out==16'($past(pc_in)+1) && done_out) else $error("not taken");
  a_flags_kept: assert property (!$past(sys_rst_in) |-> core_flag_register_out==$past(core_flag_register_in))
    else $error("flags changed");
  a_two_word_len: assert property (go && op_in==2 && io_reg_in[bit_index_in] && next_two_word_in |=>
    busy_out[*2] ##1 done_out) else $error("two word length");
  cover property (go && op_in==3);
  cover property (go && next_two_word_in);
  cover property (taken_out ##1 done_out);
endmodule
bind csb_cond_skip_branch csb_props u_props(
  .clock_in(clock_in),
  .sys_rst_in(sys_rst_in),
  .start_in(start_in),
  .next_two_word_in(next_two_word_in),
  .pc_load_out(pc_load_out),
  .taken_out(taken_out),
  .busy_out(busy_out),
  .done_out(done_out),
  .op_in(op_in),
  .bit_index_in(bit_index_in),
  .offset_in(offset_in),
  .pc_in(pc_in),
  .pc_out(pc_out),
  .work_reg_in(work_reg_in),
  .io_reg_in(io_reg_in),
  .core_flag_register_in(core_flag_register_in),
  .core_flag_register_out(core_flag_register_out)
);
